// *** adc_tick_gen.v ***
// converter clock enable: one-cycle pulse every div system clocks
// assumes restart is a one-cycle pulse that realigns the phase to a fresh conversion
module adc_tick_gen #(
    parameter integer DIV = 2,
    parameter integer CW = 2
) (
    input wire hclk,
    input wire hresetn,
    input wire restart,
    input wire run,
    output reg tick
);

    reg [CW-1:0] count_reg;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_reg <= {CW{1'b0}};
            tick <= 1'b0;
        end
        else if (restart)
        begin
            // start one count in: tick is registered, so this keeps the first period at div clocks
            count_reg <= {{(CW-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
        else if (!run)
        begin
            count_reg <= {CW{1'b0}};
            tick <= 1'b0;
        end
        else if (count_reg == DIV[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
        begin
            count_reg <= {CW{1'b0}};
            tick <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end

endmodule

// *** front_end_model.sv ***
// sample-and-hold and comparator model: input n holds level {n,n}
// assumes the sample is latched while sample_open is high
module front_end_model (
    input wire hclk,
    input wire converter_on,
    input wire sample_open,
    input wire [3:0] input_select,
    input wire [7:0] trial_code,
    output logic comp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] held = 8'h00;
    logic wiggle = 1'b0;
    always @(posedge hclk)
    begin
        wiggle <= ~wiggle;
        if (sample_open)
            held <= {input_select, input_select};
    end
    // powered down comparator gives no stable answer
    assign comp_in = converter_on ? (held >= trial_code) : wiggle;
endmodule

// *** sar_converter_control.v ***
// control, sequencing and result logic of an 8-bit successive-approximation converter
// assumes an AHB-Lite master on hclk and an analog front end whose comparator answers
// comp_in = 1 when the held sample is at or above trial_code, settled within one converter period
//
// Function
// - done flag set on result, cleared by result read or control write
// - converter_on bit switches converter on and off
// - low four bits select analog input index
// - result register read-only, eight-bit value
// - result at index 70h, control at 71h
// - reset clears both registers entirely
// - conversion lasts twelve converter clocks, two cycles each
// - setting on starts continuous back-to-back conversions
// - control write with on bit set aborts, clears flag, restarts
// - no interrupt; result held until next
`include "sar_converter_defines.vh"

module sar_converter_control #(
    parameter integer CONV_PERIODS = `CONV_PERIODS,
    parameter integer SAMPLE_PERIODS = `SAMPLE_PERIODS
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire comp_in,
    output reg [3:0] input_select,
    output reg converter_on,
    output reg sample_open,
    output reg [7:0] trial_code
);

    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_SAMPLE = 2'd1;
    localparam [1:0] ST_CONVERT = 2'd2;
    localparam [3:0] LAST_STEP = CONV_PERIODS[3:0] - 4'h1;
    localparam [3:0] FIRST_TRIAL = SAMPLE_PERIODS[3:0];

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [3:0] step_reg;
    reg [3:0] step_next;
    reg [7:0] result_reg;
    reg [7:0] result_next;
    reg [7:0] trial_next;
    reg conversion_done_flag;
    reg done_next;
    reg on_next;
    reg [3:0] select_next;
    reg wr_pending_reg;
    reg [7:0] wr_index_reg;
    reg [31:0] hrdata_next;

    wire adc_tick;
    wire addr_phase;
    wire [7:0] addr_index;
    wire wr_csr;
    wire rd_result;
    wire start_conv;
    wire finish_conv;
    wire [2:0] trial_bit;

    // answer is always zero wait state and OKAY
    assign hreadyout = 1'b1;
    assign hresp = `HRESP_OKAY;

    assign addr_phase = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
    // upper address bits are not decoded
    assign addr_index = haddr[9:2];
    // write data arrives one cycle after its address phase
    assign wr_csr = wr_pending_reg && (wr_index_reg == `CONTROL_STATUS_INDEX);
    assign rd_result = addr_phase && !hwrite && (addr_index == `RESULT_INDEX);
    // any control write with the on bit set restarts from sampling
    assign start_conv = wr_csr && hwdata[`ON_BIT];
    assign finish_conv = adc_tick && (state_reg == ST_CONVERT) && (step_reg == LAST_STEP);
    assign trial_bit = LAST_STEP[2:0] - step_reg[2:0];

    // keep the decided bit, then raise the next lower one for trial
    function [7:0] sar_step;
        input [7:0] cur;
        input [2:0] b;
        input cmp;
        integer i;
        begin
            sar_step = cur;
            for (i = 0; i < 8; i = i + 1)
            begin
                if (i == b)
                    sar_step[i] = cmp;
                else if (i + 1 == b)
                    sar_step[i] = 1'b1;
            end
        end
    endfunction

    adc_tick_gen #(
        .DIV(`CPU_PER_ADC_CLOCK),
        .CW(2)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .restart(start_conv),
        .run(converter_on),
        .tick(adc_tick)
    );

    // control register and flag
    always @*
    begin
        on_next = converter_on;
        select_next = input_select;
        done_next = conversion_done_flag;
        if (wr_csr)
        begin
            on_next = hwdata[`ON_BIT];
            select_next = hwdata[`SELECT_MSB:`SELECT_LSB];
        end
        // bits six and four are not stored, so they always read zero
        if (wr_csr || rd_result)
            done_next = 1'b0;
        if (finish_conv)
            done_next = 1'b1;
    end

    // sequencer: sample periods, then one period per result bit, msb first
    always @*
    begin
        state_next = state_reg;
        step_next = step_reg;
        trial_next = trial_code;
        result_next = result_reg;
        case (state_reg)
            ST_IDLE:
            begin
                step_next = 4'h0;
            end
            ST_SAMPLE:
            begin
                if (adc_tick)
                begin
                    step_next = step_reg + 4'h1;
                    if (step_reg == FIRST_TRIAL - 4'h1)
                        state_next = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                if (adc_tick)
                begin
                    trial_next = sar_step(trial_code, trial_bit, comp_in);
                    if (step_reg == LAST_STEP)
                    begin
                        // result and flag change in the same cycle
                        result_next = sar_step(trial_code, trial_bit, comp_in);
                        step_next = 4'h0;
                        trial_next = 8'h80;
                        state_next = ST_SAMPLE;
                    end
                    else
                    begin
                        step_next = step_reg + 4'h1;
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        if (start_conv)
        begin
            state_next = ST_SAMPLE;
            step_next = 4'h0;
            trial_next = 8'h80;
        end
        else if (!on_next)
        begin
            state_next = ST_IDLE;
            step_next = 4'h0;
        end
    end

    // control read data is built from next values so a read right after a write sees it
    always @*
    begin
        hrdata_next = 32'h0000_0000;
        if (addr_phase && !hwrite)
        begin
            if (addr_index == `RESULT_INDEX)
                hrdata_next = {24'h00_0000, result_reg};
            else if (addr_index == `CONTROL_STATUS_INDEX)
                hrdata_next = {24'h00_0000, done_next, 1'b0, on_next, 1'b0, select_next};
            else
                hrdata_next = 32'h0000_0000;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            result_reg <= `RESULT_RESET;
            conversion_done_flag <= `DONE_RESET;
            converter_on <= `ON_RESET;
            input_select <= `SELECT_RESET;
            state_reg <= ST_IDLE;
            step_reg <= 4'h0;
            trial_code <= 8'h00;
            sample_open <= 1'b0;
            wr_pending_reg <= 1'b0;
            wr_index_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            result_reg <= result_next;
            conversion_done_flag <= done_next;
            converter_on <= on_next;
            input_select <= select_next;
            state_reg <= state_next;
            step_reg <= step_next;
            trial_code <= trial_next;
            sample_open <= (state_next == ST_SAMPLE);
            wr_pending_reg <= addr_phase && hwrite;
            wr_index_reg <= addr_index;
            hrdata <= hrdata_next;
        end
    end

endmodule

// *** sar_converter_control_assertions.sv ***
// checker for the converter control block, watching only its ports
// assumes one clock hclk and an active-low asynchronous reset
module sar_converter_control_assertions #(
    parameter integer CONV_PERIODS = 12,
    parameter integer SAMPLE_PERIODS = 4
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire [3:0] input_select,
    input wire converter_on,
    input wire sample_open,
    input wire [7:0] trial_code
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer SL = SAMPLE_PERIODS * 2;
    localparam integer TL = (CONV_PERIODS - SAMPLE_PERIODS) * 2;
    logic wr_dp;
    logic rd_dp;
    logic [5:0] open_cnt;
    logic [5:0] shut_cnt;
    // length of the current sampling and trial phases; a restarting write opens a fresh sample
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            open_cnt <= 6'h00;
            shut_cnt <= 6'h00;
        end
        else
        begin
            if (!sample_open || wr_dp)
                open_cnt <= 6'h00;
            else if (open_cnt != 6'h3f)
                open_cnt <= open_cnt + 6'h01;
            if (sample_open)
                shut_cnt <= 6'h00;
            else if (shut_cnt != 6'h3f)
                shut_cnt <= shut_cnt + 6'h01;
        end
    end
    wire take = hsel && hready && htrans[1] && haddr[9:2] == 8'h71;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_dp <= 1'b0;
            rd_dp <= 1'b0;
        end
        else
        begin
            wr_dp <= take && hwrite;
            rd_dp <= take && !hwrite;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_started;
        sample_open && converter_on && trial_code == 8'h80;
    endsequence
    sequence s_sample_end;
        $fell(sample_open) && converter_on;
    endsequence
    a_bus_narrow_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
        else $error("bus answer not okay or read data too wide");
    a_reset_clears_all: assert property ($rose(hresetn) |-> !converter_on && input_select == 4'h0)
        else $error("control not clear after reset");
    a_off_no_sample: assert property (!converter_on |-> !sample_open)
        else $error("sampling while converter off");
    a_sample_length: assert property (s_sample_end |-> $past(sample_open, SL))
        else $error("sampling phase too short");
    a_trial_starts_msb: assert property (s_sample_end |-> trial_code == 8'h80)
        else $error("first trial not msb");
    a_write_restarts: assert property (wr_dp && hwdata[5] |=> s_started)
        else $error("control write did not restart conversion");
    a_ctrl_update: assert property (wr_dp |=> converter_on == $past(hwdata[5]) &&
        input_select == $past(hwdata[3:0]))
        else $error("control fields not taken from write");
    a_sample_periods: assert property (s_sample_end |-> open_cnt == SL)
        else $error("sampling phase not the sample period count");
    a_trial_periods: assert property ($rose(sample_open) && converter_on && !$past(wr_dp) |-> shut_cnt == TL)
        else $error("trial phase not the trial period count");
    a_ctrl_hold: assert property (!wr_dp |=> $stable(input_select) && $stable(converter_on))
        else $error("control fields changed without write");
    a_ctrl_readback: assert property (rd_dp |-> hrdata[6:0] == {1'b0, converter_on, 1'b0, input_select})
        else $error("control readback wrong");
endmodule
bind sar_converter_control sar_converter_control_assertions #(.CONV_PERIODS(CONV_PERIODS),
    .SAMPLE_PERIODS(SAMPLE_PERIODS)) sar_converter_control_assertions_i (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .input_select, .converter_on,
    .sample_open, .trial_code);

// *** sar_converter_control_tb_top.sv ***
// self-checking bench of the converter control over ahb-lite
// assumes the front end model on the analog side
`include "sar_converter_defines.vh"
module sar_converter_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [31:0] RES = {22'h0, `RESULT_INDEX, 2'b00};
    localparam [31:0] CTL = {22'h0, `CONTROL_STATUS_INDEX, 2'b00};
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    wire hready, hreadyout, hresp, comp_in, converter_on, sample_open;
    wire [31:0] hrdata;
    wire [3:0] input_select;
    wire [7:0] trial_code;
    int error_cnt = 0, compares = 0, cyc = 0;
    assign hready = hreadyout;
    always #2.5 hclk = ~hclk;
    sar_converter_control #(.CONV_PERIODS(12), .SAMPLE_PERIODS(4)) sar_converter_control_i (.hclk, .hresetn,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .comp_in,
        .input_select, .converter_on, .sample_open, .trial_code);
    front_end_model front_end_model_i (.hclk, .converter_on, .sample_open, .input_select, .trial_code, .comp_in);
    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input [31:0] seen, input [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic ahb(input [31:0] a, input w, input [31:0] d, output [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wait_done(output [31:0] q);
        for (int i = 0; i < 40; i++)
        begin
            ahb(CTL, 1'b0, 32'h0, q);
            if (q[7] === 1'b1)
                break;
        end
    endtask
    task automatic t_convert(input [3:0] s);
        logic [31:0] q;
        ahb(CTL, 1'b1, 32'h20 | s, q);
        ahb(CTL, 1'b0, 32'h0, q);
        chk("ctrl after start", q, 32'h20 | s);
        wait_done(q);
        chk("done set", q, 32'ha0 | s);
        ahb(RES, 1'b0, 32'h0, q);
        chk("result", q, {24'h0, s, s});
        ahb(CTL, 1'b0, 32'h0, q);
        chk("done cleared by read", q, 32'h20 | s);
        wait_done(q);
        chk("done again", q, 32'ha0 | s);
    endtask
    task automatic t_access();
        logic [31:0] q;
        ahb(RES, 1'b1, 32'haa, q);
        ahb(RES, 1'b0, 32'h0, q);
        chk("result after write", q, 32'hff);
        ahb(32'h100, 1'b0, 32'h0, q);
        chk("unmapped read", q, 32'h0);
        ahb(CTL, 1'b1, 32'h0, q);
        repeat (60) @(posedge hclk);
        ahb(CTL, 1'b0, 32'h0, q);
        chk("ctrl when off", q, 32'h0);
        ahb(RES, 1'b0, 32'h0, q);
        chk("result kept", q, 32'hff);
    endtask
    task automatic t_reset();
        logic [31:0] q;
        ahb(CTL, 1'b1, 32'h23, q);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(RES, 1'b0, 32'h0, q);
        chk("result after reset", q, 32'h0);
        ahb(CTL, 1'b0, 32'h0, q);
        chk("ctrl after reset", q, 32'h0);
    endtask
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            conclude();
        end
    end
    initial
    begin
        logic [31:0] q;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(RES, 1'b0, 32'h0, q);
        chk("result reset", q, 32'h0);
        ahb(CTL, 1'b0, 32'h0, q);
        chk("ctrl reset", q, 32'h0);
        t_convert(4'h0);
        t_convert(4'h5);
        t_convert(4'hf);
        t_access();
        t_reset();
        conclude();
    end
endmodule

// *** sar_converter_defines.vh ***
// register offsets, field positions, reset values and timing counts of the converter control
// assumes the includer uses them with a 32-bit AHB-Lite data path
`ifndef SAR_CONVERTER_DEFINES_VH
`define SAR_CONVERTER_DEFINES_VH

// register indices; byte address is four times the index
`define RESULT_INDEX 8'h70
`define CONTROL_STATUS_INDEX 8'h71

// control_status_register fields
`define DONE_BIT 7
`define ON_BIT 5
`define SELECT_MSB 3
`define SELECT_LSB 0

// reset values
`define RESULT_RESET 8'h00
`define SELECT_RESET 4'h0
`define DONE_RESET 1'b0
`define ON_RESET 1'b0

// timing: converter clock periods per conversion, of which the first ones load the sample
`define CONV_PERIODS 4'hc
`define SAMPLE_PERIODS 4'h4
`define CPU_PER_ADC_CLOCK 2

// ahb-lite codes
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif
